// [pkg/table_access_pkg.sv]
// Constants for the program memory table access block
package table_access_pkg;
  localparam int PTR_W = 22;
  localparam int LOW_W = 21;
  localparam logic [11:0] OFF_CTRL   = 12'h000;
  localparam logic [11:0] OFF_PTR    = 12'h004;
  localparam logic [11:0] OFF_LATCH  = 12'h008;
  localparam logic [11:0] OFF_CMD    = 12'h00C;
  localparam logic [11:0] OFF_STATUS = 12'h010;
  localparam int CTRL_LWE_BIT = 0;
  localparam int CMD_WRITE_BIT = 0;
  localparam int CMD_MODE_LSB = 1;
  localparam int ST_PROG_BIT = 0;
  localparam int ST_SLEEP_BIT = 1;
  localparam int ST_VPP_BIT = 2;
  localparam int ST_REFUSED_BIT = 3;
  localparam int ST_HOLD_VALID_BIT = 4;
  localparam logic [PTR_W-1:0] PTR_RESET = 22'h000000;
  localparam logic [7:0] LATCH_RESET = 8'h00;
  localparam logic [7:0] ID_SPACE_READ = 8'h00;
  typedef enum logic [1:0]
  {
    PTR_KEEP     = 2'b00,
    PTR_POST_INC = 2'b01,
    PTR_POST_DEC = 2'b10,
    PTR_PRE_INC  = 2'b11
  } ptr_mode_t;
  typedef enum logic [0:0]
  {
    ST_IDLE = 1'b0,
    ST_PROG = 1'b1
  } prog_state_t;
endpackage

// [rtl/prog_word_mem.sv]
// Program memory word array with word-addressed read port
`timescale 1ns/1ns
`default_nettype none
module prog_word_mem #(
  parameter int AW = 10
) (
  input  wire logic          pclk,
  input  wire logic [AW-1:0] rd_addr,
  output logic      [15:0]   rd_word,
  input  wire logic          wr_en,
  input  wire logic [AW-1:0] wr_addr,
  input  wire logic [15:0]   wr_word
);
  logic [15:0] mem [0:(1<<AW)-1];

  // Contents undefined until programmed, as erased cells would be
  always_ff @(posedge pclk)
  begin
    if (wr_en)
    begin
      mem[wr_addr] <= wr_word;
    end
  end

  assign rd_word = mem[rd_addr];
endmodule
`default_nettype wire

// [rtl/table_access.sv]
// Table read and table write engine for internal program memory
//
// The placing of the registers and the APB slave port are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none
module table_access #(
  parameter int AW = 10
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        master_clear_prog_voltage_pin,
  input  wire logic        term_int_flag,
  input  wire logic        term_int_enable,
  input  wire logic        term_int_priority_high,
  input  wire logic        global_high_int_enable,
  input  wire logic        peripheral_low_int_enable,
  output logic             exec_halt,
  output logic             core_sleep,
  output logic             prog_voltage_apply,
  output logic             vector_high,
  output logic             vector_low,
  output logic             resume_next
);
  localparam int PW = table_access_pkg::PTR_W;
  localparam int LW = table_access_pkg::LOW_W;

  logic [PW-1:0]  table_pointer_reg;
  logic [PW-1:0]  table_pointer_next;
  logic [7:0]     table_latch_reg;
  logic [7:0]     holding_reg;
  logic           hold_valid_reg;
  logic           long_write_enable_reg;
  logic           refused_reg;
  logic           vpp_meta_reg;
  logic           vpp_sync_reg;
  logic [AW-1:0]  prog_addr_reg;
  logic [15:0]    prog_word_reg;
  logic           mem_wr_en;
  logic [15:0]    rd_word;
  logic [PW-1:0]  access_addr;
  logic [7:0]     read_byte;
  logic           apb_write;
  logic           cmd_go;
  logic           cmd_is_write;
  logic           ends_prog;
  logic           start_long;
  table_access_pkg::ptr_mode_t   cmd_mode;
  table_access_pkg::prog_state_t state_reg;
  table_access_pkg::prog_state_t state_next;

  // Low 21 bits step, top bit kept
  function automatic logic [PW-1:0] ptr_step(input logic [PW-1:0] p,
                                             input logic dec);
    logic [LW-1:0] low;
    low = dec ? p[LW-1:0] - 21'h000001 : p[LW-1:0] + 21'h000001;
    return {p[PW-1], low};
  endfunction

  assign apb_write = psel && penable && pwrite;
  assign pready = 1'b1;
  assign pslverr = psel && penable &&
    !(paddr == table_access_pkg::OFF_CTRL ||
      paddr == table_access_pkg::OFF_PTR ||
      paddr == table_access_pkg::OFF_LATCH ||
      paddr == table_access_pkg::OFF_CMD ||
      paddr == table_access_pkg::OFF_STATUS);

  // Command word: bit 0 write, bits 2:1 pointer mode
  assign cmd_go = apb_write && paddr == table_access_pkg::OFF_CMD &&
                  state_reg == table_access_pkg::ST_IDLE;
  assign cmd_is_write = pwdata[table_access_pkg::CMD_WRITE_BIT];
  assign cmd_mode = table_access_pkg::ptr_mode_t'(
    pwdata[table_access_pkg::CMD_MODE_LSB +: 2]);

  // Pre-increment moves the pointer before the access
  assign access_addr = (cmd_mode == table_access_pkg::PTR_PRE_INC) ?
                       ptr_step(table_pointer_reg, 1'b0) :
                       table_pointer_reg;

  // Identification space has no array behind it here
  assign read_byte = access_addr[PW-1] ? table_access_pkg::ID_SPACE_READ :
                     (access_addr[0] ? rd_word[15:8] : rd_word[7:0]);

  assign start_long = cmd_go && cmd_is_write && !access_addr[PW-1] &&
                      access_addr[0] && long_write_enable_reg &&
                      vpp_sync_reg;

  // Source enable alone qualifies; globals only steer the vector
  assign ends_prog = term_int_enable && term_int_flag;

  prog_word_mem #(
    .AW (AW)
  ) u_mem (
    .pclk    (pclk),
    .rd_addr (access_addr[AW:1]),
    .rd_word (rd_word),
    .wr_en   (mem_wr_en),
    .wr_addr (prog_addr_reg),
    .wr_word (prog_word_reg)
  );

  // Pin from outside the clock domain
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      vpp_meta_reg <= 1'b0;
      vpp_sync_reg <= 1'b0;
    end
    else
    begin
      vpp_meta_reg <= master_clear_prog_voltage_pin;
      vpp_sync_reg <= vpp_meta_reg;
    end
  end

  // Writes of zero are ignored so a stray clear cannot lock out software
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      long_write_enable_reg <= 1'b0;
    end
    else if (apb_write && paddr == table_access_pkg::OFF_CTRL &&
             pwdata[table_access_pkg::CTRL_LWE_BIT])
    begin
      long_write_enable_reg <= 1'b1;
    end
  end

  always_comb
  begin
    table_pointer_next = table_pointer_reg;
    if (apb_write && paddr == table_access_pkg::OFF_PTR &&
        state_reg == table_access_pkg::ST_IDLE)
    begin
      table_pointer_next = pwdata[PW-1:0];
    end
    else if (cmd_go)
    begin
      case (cmd_mode)
        table_access_pkg::PTR_KEEP:
          table_pointer_next = table_pointer_reg;
        table_access_pkg::PTR_POST_INC:
          table_pointer_next = ptr_step(table_pointer_reg, 1'b0);
        table_access_pkg::PTR_POST_DEC:
          table_pointer_next = ptr_step(table_pointer_reg, 1'b1);
        table_access_pkg::PTR_PRE_INC:
          table_pointer_next = access_addr;
        default:
          table_pointer_next = table_pointer_reg;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      table_pointer_reg <= table_access_pkg::PTR_RESET;
    end
    else
    begin
      table_pointer_reg <= table_pointer_next;
    end
  end

  // Latch takes software writes and table read data
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      table_latch_reg <= table_access_pkg::LATCH_RESET;
    end
    else if (cmd_go && !cmd_is_write)
    begin
      table_latch_reg <= read_byte;
    end
    else if (apb_write && paddr == table_access_pkg::OFF_LATCH &&
             state_reg == table_access_pkg::ST_IDLE)
    begin
      table_latch_reg <= pwdata[7:0];
    end
  end

  // Holding register has no bus decode at all
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      holding_reg <= 8'h00;
      hold_valid_reg <= 1'b0;
    end
    else if (cmd_go && cmd_is_write && !access_addr[PW-1] &&
             !access_addr[0])
    begin
      holding_reg <= table_latch_reg;
      hold_valid_reg <= 1'b1;
    end
    else if (start_long)
    begin
      hold_valid_reg <= 1'b0;
    end
  end

  // Block word assembled from holding and latch
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prog_addr_reg <= '0;
      prog_word_reg <= 16'h0000;
    end
    else if (start_long)
    begin
      prog_addr_reg <= access_addr[AW:1];
      prog_word_reg <= {table_latch_reg, holding_reg};
    end
  end

  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      table_access_pkg::ST_IDLE:
        if (start_long)
        begin
          state_next = table_access_pkg::ST_PROG;
        end
      table_access_pkg::ST_PROG:
        if (ends_prog)
        begin
          state_next = table_access_pkg::ST_IDLE;
        end
      default:
        state_next = table_access_pkg::ST_IDLE;
    endcase
  end

  // No timeout: software owns the programming time
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_reg <= table_access_pkg::ST_IDLE;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  // Array is written once the voltage is applied, on the last cycle
  assign mem_wr_en = state_reg == table_access_pkg::ST_PROG && ends_prog;
  assign exec_halt = state_reg == table_access_pkg::ST_PROG;
  assign core_sleep = state_reg == table_access_pkg::ST_PROG;
  assign prog_voltage_apply = state_reg == table_access_pkg::ST_PROG;

  // Outcome pulses; flag itself is left to software
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      vector_high <= 1'b0;
      vector_low <= 1'b0;
      resume_next <= 1'b0;
    end
    else
    begin
      vector_high <= 1'b0;
      vector_low <= 1'b0;
      resume_next <= 1'b0;
      if (mem_wr_en)
      begin
        if (global_high_int_enable && !peripheral_low_int_enable &&
            term_int_priority_high)
        begin
          vector_high <= 1'b1;
        end
        else if (!global_high_int_enable && peripheral_low_int_enable &&
                 !term_int_priority_high)
        begin
          vector_low <= 1'b1;
        end
        else
        begin
          resume_next <= 1'b1;
        end
      end
    end
  end

  // Commands arriving during programming are dropped and flagged
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      refused_reg <= 1'b0;
    end
    else if (apb_write && paddr == table_access_pkg::OFF_CMD &&
             state_reg == table_access_pkg::ST_PROG)
    begin
      refused_reg <= 1'b1;
    end
    else if (apb_write && paddr == table_access_pkg::OFF_STATUS &&
             pwdata[table_access_pkg::ST_REFUSED_BIT])
    begin
      refused_reg <= 1'b0;
    end
  end

  always_comb
  begin
    prdata = 32'h00000000;
    case (paddr)
      table_access_pkg::OFF_CTRL:
        prdata[table_access_pkg::CTRL_LWE_BIT] = long_write_enable_reg;
      table_access_pkg::OFF_PTR:
        prdata[PW-1:0] = table_pointer_reg;
      table_access_pkg::OFF_LATCH:
        prdata[7:0] = table_latch_reg;
      table_access_pkg::OFF_STATUS:
      begin
        prdata[table_access_pkg::ST_PROG_BIT] = exec_halt;
        prdata[table_access_pkg::ST_SLEEP_BIT] = core_sleep;
        prdata[table_access_pkg::ST_VPP_BIT] = vpp_sync_reg;
        prdata[table_access_pkg::ST_REFUSED_BIT] = refused_reg;
        prdata[table_access_pkg::ST_HOLD_VALID_BIT] = hold_valid_reg;
      end
      default:
        prdata = 32'h00000000;
    endcase
  end

  property p_even_short;
    @(posedge pclk) disable iff (!presetn)
    (cmd_go && cmd_is_write && !access_addr[0]) |=> exec_halt == 1'b0;
  endproperty
  a_even_short: assert property (p_even_short)
    else $error("even write started programming");

  property p_long_cond;
    @(posedge pclk) disable iff (!presetn)
    $rose(exec_halt) |-> $past(long_write_enable_reg) &&
      $past(vpp_sync_reg) && $past(access_addr[0]) && $past(cmd_is_write);
  endproperty
  a_long_cond: assert property (p_long_cond)
    else $error("long write without all conditions");

  property p_lwe_sticky;
    @(posedge pclk) disable iff (!presetn)
    long_write_enable_reg |=> long_write_enable_reg;
  endproperty
  a_lwe_sticky: assert property (p_lwe_sticky)
    else $error("long write enable cleared without reset");

  property p_term;
    @(posedge pclk) disable iff (!presetn)
    (exec_halt && term_int_enable && term_int_flag) |=>
      !exec_halt && (vector_high || vector_low || resume_next);
  endproperty
  a_term: assert property (p_term)
    else $error("enabled flag did not end programming");

  property p_hold_on;
    @(posedge pclk) disable iff (!presetn)
    (exec_halt && !term_int_enable) |=> exec_halt;
  endproperty
  a_hold_on: assert property (p_hold_on)
    else $error("long write ended with source disabled");

  property p_vec_high;
    @(posedge pclk) disable iff (!presetn)
    vector_high |-> $past(global_high_int_enable) &&
      !$past(peripheral_low_int_enable) && $past(term_int_priority_high) &&
      $past(exec_halt);
  endproperty
  a_vec_high: assert property (p_vec_high)
    else $error("wrong high vector");

  property p_vec_low;
    @(posedge pclk) disable iff (!presetn)
    (exec_halt && ends_prog && !global_high_int_enable &&
     peripheral_low_int_enable && !term_int_priority_high) |=>
      vector_low && !resume_next;
  endproperty
  a_vec_low: assert property (p_vec_low)
    else $error("low vector missing");

  property p_ptr_top;
    @(posedge pclk) disable iff (!presetn)
    cmd_go |=> table_pointer_reg[PW-1] == $past(table_pointer_reg[PW-1]);
  endproperty
  a_ptr_top: assert property (p_ptr_top)
    else $error("pointer top bit changed by table op");

  property p_read;
    @(posedge pclk) disable iff (!presetn)
    (cmd_go && !cmd_is_write && !access_addr[PW-1]) |=>
      table_latch_reg == $past(access_addr[0] ? rd_word[15:8] :
                                                rd_word[7:0]);
  endproperty
  a_read: assert property (p_read)
    else $error("table read byte wrong");
endmodule
`default_nettype wire

// [verif/core_int_model.sv]
// Behavioural core and terminating interrupt source for the bench
`timescale 1ns/1ns
`default_nettype none
module core_int_model (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       exec_halt,
  input  wire logic       vector_high,
  input  wire logic       vector_low,
  input  wire logic       resume_next,
  input  wire logic [7:0] delay,
  input  wire logic       flag_clear,
  output logic            term_int_flag,
  output logic [1:0]      last_kind,
  output logic [7:0]      pulse_count
);
  logic [7:0] halt_cnt_reg;

  // Source fires a set time into the halt, like a timer armed before
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      halt_cnt_reg <= 8'h00;
    else
      halt_cnt_reg <= exec_halt ? halt_cnt_reg + 8'h01 : 8'h00;
  end

  // Flag is never cleared by hardware, only on a software request
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      term_int_flag <= 1'b0;
    else if (flag_clear)
      term_int_flag <= 1'b0;
    else if (exec_halt && halt_cnt_reg == delay)
      term_int_flag <= 1'b1;
  end

  // Kind code: 1 high vector, 2 low vector, 3 next instruction
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      last_kind <= 2'b00;
      pulse_count <= 8'h00;
    end
    else if (vector_high || vector_low || resume_next)
    begin
      last_kind <= {vector_low || resume_next, vector_high || resume_next};
      pulse_count <= pulse_count + 8'h01;
    end
  end
endmodule
`default_nettype wire

// [verif/table_access_tb.sv]
// Self-checking bench for the table access block
`timescale 1ns/1ns
`default_nettype none
module table_access_tb;
  localparam logic [11:0] A_CTRL = table_access_pkg::OFF_CTRL;
  localparam logic [11:0] A_PTR  = table_access_pkg::OFF_PTR;
  localparam logic [11:0] A_LAT  = table_access_pkg::OFF_LATCH;
  localparam logic [11:0] A_CMD  = table_access_pkg::OFF_CMD;
  localparam logic [11:0] A_ST   = table_access_pkg::OFF_STATUS;
  localparam logic [31:0] W_KEEP = 32'h00000001;
  localparam logic [31:0] W_INC  = 32'h00000003;
  localparam logic [31:0] R_INC  = 32'h00000002;
  localparam logic [31:0] R_DEC  = 32'h00000004;
  localparam logic [31:0] R_PRE  = 32'h00000006;
  localparam logic [5:0]  GH_T   = 6'h34;
  localparam logic [5:0]  GL_T   = 6'h2A;
  localparam logic [5:0]  PR_T   = 6'h33;
  localparam logic [11:0] KIND_T = 12'hDBF;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic        vpp, flag, en, prio, gh, gl, flag_clear, last_err;
  logic        halt, sleep, pva, vh, vl, rn;
  logic [7:0]  delay, pcount;
  logic [1:0]  kind;
  logic [21:0] base;
  int          fail_count, checks, cycles, i, n;

  table_access #(.AW(10)) i_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr),
    .master_clear_prog_voltage_pin(vpp), .term_int_flag(flag),
    .term_int_enable(en), .term_int_priority_high(prio),
    .global_high_int_enable(gh), .peripheral_low_int_enable(gl),
    .exec_halt(halt), .core_sleep(sleep), .prog_voltage_apply(pva),
    .vector_high(vh), .vector_low(vl), .resume_next(rn)
  );

  core_int_model i_core (
    .pclk(pclk), .presetn(presetn), .exec_halt(halt), .vector_high(vh),
    .vector_low(vl), .resume_next(rn), .delay(delay),
    .flag_clear(flag_clear), .term_int_flag(flag), .last_kind(kind),
    .pulse_count(pcount)
  );

  initial
  begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end

  task automatic results;
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // Hang guard well above the few hundred cycles the run needs
  initial
  begin
    cycles = 0;
    forever
    begin
      @(posedge pclk);
      cycles++;
      if (cycles == 20000)
      begin
        fail_count++;
        results();
      end
    end
  end

  task automatic tick(input int k);
    repeat (k) @(posedge pclk);
  endtask

  task automatic chk_word(input string nm, input logic [31:0] e,
                          input logic [31:0] g);
    checks++;
    if (g !== e)
    begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic chk_bit(input string nm, input logic e, input logic g);
    chk_word(nm, {31'h0, e}, {31'h0, g});
  endtask

  // Request held until pready is seen high at a rising edge
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    // Only the bench timeout ends a stalled access
    while (pready !== 1'b1)
    begin
      @(posedge pclk);
    end
    q = prdata;
    last_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    apb(1'b1, a, d, q);
  endtask

  task automatic rd(input string nm, input logic [11:0] a,
                    input logic [31:0] m, input logic [31:0] e);
    logic [31:0] q;
    apb(1'b0, a, 32'h0, q);
    chk_word(nm, e, q & m);
  endtask

  task automatic tbl(input logic [21:0] p, input logic [7:0] l,
                     input logic [31:0] c);
    wr(A_PTR, {10'h000, p});
    wr(A_LAT, {24'h000000, l});
    wr(A_CMD, c);
  endtask

  initial
  begin
    {psel, penable, pwrite, vpp, en, prio, gh, gl, flag_clear} = '0;
    presetn = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    delay = 8'h06;
    fail_count = 0;
    checks = 0;
    tick(6);
    presetn <= 1'b1;
    rd("ctrl", A_CTRL, '1, 32'h0);
    rd("ptr", A_PTR, '1, {10'h0, table_access_pkg::PTR_RESET});
    rd("latch", A_LAT, '1, {24'h0, table_access_pkg::LATCH_RESET});
    rd("status", A_ST, '1, 32'h0);
    rd("unmapped", 12'h100, '1, 32'h0);
    chk_bit("slverr", 1'b1, last_err);
    vpp <= 1'b1;
    tick(3);
    rd("vpp", A_ST, 32'h4, 32'h4);
    tbl(22'h10, 8'hA5, W_KEEP);
    rd("hold", A_ST, 32'h10, 32'h10);
    tbl(22'h11, 8'h5A, W_KEEP);
    tick(3);
    chk_bit("halt", 1'b0, halt);
    wr(A_CTRL, 32'h1);
    wr(A_CTRL, 32'h0);
    rd("lwe", A_CTRL, 32'h1, 32'h1);
    vpp <= 1'b0;
    tick(3);
    tbl(22'h11, 8'h5A, W_KEEP);
    tick(3);
    chk_bit("halt", 1'b0, halt);
    vpp <= 1'b1;
    tick(3);
    wr(A_PTR, 32'h003FFFFF);
    wr(A_CMD, R_INC);
    rd("ptr", A_PTR, '1, 32'h00200000);
    wr(A_CMD, R_DEC);
    rd("ptr", A_PTR, '1, 32'h003FFFFF);
    rd("id", A_LAT, '1, {24'h0, table_access_pkg::ID_SPACE_READ});
    tbl(22'h200001, 8'h77, W_KEEP);
    tick(3);
    chk_bit("halt", 1'b0, halt);
    for (i = 0; i < 6; i++)
    begin
      base = 22'h20 + 22'(2 * i);
      gh <= GH_T[i];
      gl <= GL_T[i];
      prio <= PR_T[i];
      en <= (i != 0);
      flag_clear <= 1'b1;
      tick(1);
      flag_clear <= 1'b0;
      tbl(base, {4'h3, 4'(i)}, W_INC);
      tick(2);
      chk_bit("halt", 1'b0, halt);
      wr(A_LAT, {24'h0, 4'hC, 4'(i)});
      wr(A_CMD, W_KEEP);
      tick(2);
      chk_bit("halt", 1'b1, halt);
      chk_bit("sleep", 1'b1, sleep);
      chk_bit("voltage", 1'b1, pva);
      if (i == 0)
      begin
        tick(20);
        chk_bit("halt", 1'b1, halt);
        wr(A_PTR, 32'h0);
        wr(A_CMD, W_KEEP);
        rd("status", A_ST, 32'hF, 32'hF);
        rd("ptr", A_PTR, '1, {10'h0, base + 22'h1});
        en <= 1'b1;
      end
      n = 0;
      while (halt !== 1'b0 && n < 100)
      begin
        tick(1);
        n++;
      end
      tick(2);
      chk_bit("halt", 1'b0, halt);
      chk_word("vector", {30'h0, KIND_T[2*i +: 2]}, {30'h0, kind});
      chk_word("pulses", 32'(i + 1), {24'h0, pcount});
      wr(A_PTR, {10'h0, base - 22'h1});
      wr(A_CMD, R_PRE);
      rd("low", A_LAT, '1, {24'h0, 4'h3, 4'(i)});
      wr(A_CMD, R_PRE);
      rd("high", A_LAT, '1, {24'h0, 4'hC, 4'(i)});
    end
    wr(A_ST, 32'h8);
    rd("refused", A_ST, 32'h8, 32'h0);
    flag_clear <= 1'b1;
    en <= 1'b0;
    tick(1);
    flag_clear <= 1'b0;
    tbl(22'h40, 8'h11, W_INC);
    wr(A_LAT, 32'h22);
    wr(A_CMD, W_KEEP);
    tick(2);
    chk_bit("halt", 1'b1, halt);
    presetn <= 1'b0;
    tick(1);
    chk_bit("halt", 1'b0, halt);
    presetn <= 1'b1;
    rd("lwe", A_CTRL, 32'h1, 32'h0);
    // Aborted write must leave earlier programmed words intact
    wr(A_PTR, 32'h00000020);
    wr(A_CMD, R_INC);
    rd("verify", A_LAT, '1, 32'h00000030);
    wr(A_CMD, R_INC);
    rd("verify", A_LAT, '1, 32'h000000C0);
    results();
  end
endmodule
`default_nettype wire
